// ==== src/hjm_measure_ctrl.sv ====
module hjm_measure_ctrl #(
    parameter int STARTUP_CYCLES   = hjm_pkg::STARTUP_CYC,
    parameter int CONV_CYCLES      = hjm_pkg::CONV_CYC,
    parameter int WAIT_NORM_CYCLES = hjm_pkg::WAIT_NORM_CYC,
    parameter int WAIT_IDLE_CYCLES = hjm_pkg::WAIT_IDLE_CYC,
    parameter int CNT_W            = 24
) (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic               clk_link,
    input  wire logic               hard_reset_low,
    input  wire logic               scl_pin,
    input  wire logic               sda_pin_in,
    output      logic               sda_pin_out,
    output      logic               sda_pin_oe,
    input  wire logic               addr_sel,
    input  wire hjm_pkg::hjm_coord_t fe_coord,
    output      logic               fe_start,
    output      logic               interrupt_request_low
);
    import hjm_pkg::*;

    if (STARTUP_CYCLES < 1 || CONV_CYCLES < 1 || WAIT_NORM_CYCLES < 1 ||
        WAIT_IDLE_CYCLES < 1 || longint'(WAIT_IDLE_CYCLES) * 8 >= (longint'(1) << CNT_W) ||
        longint'(STARTUP_CYCLES) >= (longint'(1) << CNT_W)) begin : g_bad_param
        $error("hjm_measure_ctrl: counts must be positive and fit the counter");
    end

    // ---------------- Link domain: pins, slave port, register file ----------------
    logic [2:0]   pins_f;
    logic [7:0]   ptr;
    logic         sda_drive;
    hjm_reg_req_t req;
    logic [7:0]   rd_data;

    hjm_sync_filter #(.W(3), .RST_VAL(3'b011)) u_pin_filt (
        .clk   (clk_link),
        .rst_n (rst_n),
        .d     ({addr_sel, scl_pin, sda_pin_in}),
        .q     (pins_f)
    );

    hjm_i2c_slave u_slave (
        .clk_link  (clk_link),
        .rst_n     (rst_n),
        .scl_in    (pins_f[1]),
        .sda_in    (pins_f[0]),
        .addr_pin  (pins_f[2]),
        .rd_data   (rd_data),
        .ptr       (ptr),
        .sda_drive (sda_drive),
        .req       (req)
    );

    // The port only ever pulls the data line low; the clock line is input only.
    assign sda_pin_out = 1'b0;
    assign sda_pin_oe  = sda_drive;

    hjm_ctrl_t  ctrl_r,     ctrl_nxt;
    logic [7:0] shape_r     [SHAPE_NUM];
    logic [7:0] shape_nxt   [SHAPE_NUM];
    hjm_coord_t coord_l_r,  coord_l_nxt;
    logic       soft_tgl_r, soft_tgl_nxt;
    logic       rdclr_tgl_r, rdclr_tgl_nxt;
    logic [2:0] init_s_r;
    logic [2:0] coord_s_r;
    logic       init_tgl_r;
    logic       coord_tgl_r;
    hjm_coord_t coord_c_r;

    function automatic logic [7:0] rd_byte(input logic [7:0] a, input hjm_ctrl_t c,
                                           input hjm_coord_t xy, input logic [23:0] sh);
        logic [7:0] v;
        v = 8'h00;
        if (a == REG_CTRL) v = c;
        if (a == REG_X) v = xy.x;
        if (a == REG_Y) v = xy.y;
        if (a == REG_SHAPE_A) v = sh[23:16];
        if (a == REG_SHAPE_B) v = sh[15:8];
        if (a == REG_SHAPE_C) v = sh[7:0];
        return v;
    endfunction

    assign rd_data = rd_byte(ptr, ctrl_r, coord_l_r, {shape_r[0], shape_r[1], shape_r[2]});

    always_comb begin
        ctrl_nxt      = ctrl_r;
        shape_nxt     = shape_r;
        coord_l_nxt   = coord_l_r;
        soft_tgl_nxt  = soft_tgl_r;
        rdclr_tgl_nxt = rdclr_tgl_r;
        if (coord_s_r[1] ^ coord_s_r[2]) begin
            coord_l_nxt = coord_c_r;
        end
        if (init_s_r[1] ^ init_s_r[2]) begin
            ctrl_nxt    = CTRL_RST;
            coord_l_nxt = {COORD_RST, COORD_RST};
            for (int i = 0; i < SHAPE_NUM; i++) begin
                shape_nxt[i] = SHAPE_RST;
            end
        end else if (req.wr) begin
            if (req.addr == REG_CTRL) begin
                if (req.wdata[1]) begin
                    ctrl_nxt     = CTRL_RST;
                    coord_l_nxt  = {COORD_RST, COORD_RST};
                    soft_tgl_nxt = ~soft_tgl_r;
                    for (int i = 0; i < SHAPE_NUM; i++) begin
                        shape_nxt[i] = SHAPE_RST;
                    end
                end else begin
                    ctrl_nxt      = req.wdata;
                    ctrl_nxt.rsvd = 1'b0;
                end
            end
            for (int i = 0; i < SHAPE_NUM; i++) begin
                if (req.addr == REG_SHAPE_A + 8'(i)) begin
                    shape_nxt[i] = req.wdata;
                end
            end
        end
        if (req.rd && req.addr == REG_Y) begin
            rdclr_tgl_nxt = ~rdclr_tgl_r;
        end
    end

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r      <= CTRL_RST;
            coord_l_r   <= {COORD_RST, COORD_RST};
            soft_tgl_r  <= 1'b0;
            rdclr_tgl_r <= 1'b0;
            init_s_r    <= 3'b000;
            coord_s_r   <= 3'b000;
            for (int i = 0; i < SHAPE_NUM; i++) begin
                shape_r[i] <= SHAPE_RST;
            end
        end else begin
            ctrl_r      <= ctrl_nxt;
            shape_r     <= shape_nxt;
            coord_l_r   <= coord_l_nxt;
            soft_tgl_r  <= soft_tgl_nxt;
            rdclr_tgl_r <= rdclr_tgl_nxt;
            init_s_r    <= {init_s_r[1:0], init_tgl_r};
            coord_s_r   <= {coord_s_r[1:0], coord_tgl_r};
        end
    end

    // ---------------- Core domain: reset handling and measurement sequencer ----------------
    typedef enum logic [1:0] {
        ST_STARTUP = 2'b00,
        ST_MEASURE = 2'b01,
        ST_SETINT  = 2'b11,
        ST_WAIT    = 2'b10
    } hjm_seq_state_t;

    logic           hrst_f;
    logic [2:0]     soft_s_r;
    logic [2:0]     rdclr_s_r;
    hjm_ctrl_t      ctrl_s1_r;
    hjm_ctrl_t      ctrl_s2_r;
    hjm_ctrl_t      ctrl_c_r,   ctrl_c_nxt;
    logic [1:0]     hrst_cnt_r, hrst_cnt_nxt;
    hjm_seq_state_t st_r,       st_nxt;
    logic [CNT_W-1:0] cnt_r,    cnt_nxt;
    logic [CNT_W-1:0] wait_lim;
    hjm_coord_t     coord_c_nxt;
    hjm_coord_t     prev_r,     prev_nxt;
    logic           coord_tgl_nxt;
    logic           init_tgl_nxt;
    logic           int_r,      int_nxt;
    logic           start_r,    start_nxt;
    logic           hrst_evt;
    logic           soft_evt;
    logic           rdclr_evt;
    logic           int_cond;

    hjm_sync_filter #(.W(1), .RST_VAL(1'b1)) u_rst_filt (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (hard_reset_low),
        .q     (hrst_f)
    );

    assign hrst_evt  = !hrst_f && (hrst_cnt_r == 2'(HRST_CYC - 1));
    assign soft_evt  = soft_s_r[1] ^ soft_s_r[2];
    assign rdclr_evt = rdclr_s_r[1] ^ rdclr_s_r[2];
    assign wait_lim  = ctrl_c_r.idle ? CNT_W'(WAIT_IDLE_CYCLES * (ctrl_c_r.timebase + 1))
                                     : CNT_W'(WAIT_NORM_CYCLES * (ctrl_c_r.timebase + 1));

    always_comb begin
        unique case (hjm_int_mode_t'(ctrl_c_r.int_mode))
            INT_EVERY:     int_cond = 1'b1;
            INT_OFFCENTER: int_cond = (coord_c_r.x != 8'h00) || (coord_c_r.y != 8'h00);
            INT_CHANGE:    int_cond = (coord_c_r != prev_r);
            INT_OFF:       int_cond = 1'b0;
        endcase
    end

    always_comb begin
        // The control word crosses bit by bit, so it is taken only once two
        // successive samples agree and no half-updated word is ever used.
        ctrl_c_nxt    = (ctrl_s1_r == ctrl_s2_r) ? ctrl_s2_r : ctrl_c_r;
        hrst_cnt_nxt  = hrst_f ? 2'h0 : hrst_cnt_r;
        st_nxt        = st_r;
        cnt_nxt       = cnt_r + 1'b1;
        coord_c_nxt   = coord_c_r;
        prev_nxt      = prev_r;
        coord_tgl_nxt = coord_tgl_r;
        init_tgl_nxt  = init_tgl_r;
        int_nxt       = int_r;
        start_nxt     = 1'b0;
        if (!hrst_f && hrst_cnt_r != 2'(HRST_CYC)) begin
            hrst_cnt_nxt = hrst_cnt_r + 2'h1;
        end
        if (rdclr_evt) begin
            int_nxt = 1'b0;
        end
        if (hrst_evt || soft_evt || (!hrst_f && hrst_cnt_r == 2'(HRST_CYC))) begin
            st_nxt       = ST_STARTUP;
            cnt_nxt      = '0;
            coord_c_nxt  = {COORD_RST, COORD_RST};
            prev_nxt     = {COORD_RST, COORD_RST};
            int_nxt      = 1'b0;
            init_tgl_nxt = hrst_evt ? ~init_tgl_r : init_tgl_r;
        end else begin
            unique case (st_r)
                ST_STARTUP: begin
                    if (cnt_r == CNT_W'(STARTUP_CYCLES - 1)) begin
                        st_nxt    = ST_MEASURE;
                        cnt_nxt   = '0;
                        start_nxt = 1'b1;
                    end
                end
                ST_MEASURE: begin
                    if (cnt_r == CNT_W'(CONV_CYCLES - 1)) begin
                        prev_nxt      = coord_c_r;
                        coord_c_nxt   = fe_coord;
                        coord_tgl_nxt = ~coord_tgl_r;
                        st_nxt        = ST_SETINT;
                    end
                end
                ST_SETINT: begin
                    if (int_cond) begin
                        int_nxt = 1'b1;
                    end
                    st_nxt  = ST_WAIT;
                    cnt_nxt = '0;
                end
                ST_WAIT: begin
                    if (cnt_r >= wait_lim - 1'b1) begin
                        st_nxt    = ST_MEASURE;
                        cnt_nxt   = '0;
                        start_nxt = 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            soft_s_r    <= 3'b000;
            rdclr_s_r   <= 3'b000;
            ctrl_s1_r   <= CTRL_RST;
            ctrl_s2_r   <= CTRL_RST;
            ctrl_c_r    <= CTRL_RST;
            hrst_cnt_r  <= 2'h0;
            st_r        <= ST_STARTUP;
            cnt_r       <= '0;
            coord_c_r   <= {COORD_RST, COORD_RST};
            prev_r      <= {COORD_RST, COORD_RST};
            coord_tgl_r <= 1'b0;
            init_tgl_r  <= 1'b0;
            int_r       <= 1'b0;
            start_r     <= 1'b0;
        end else begin
            soft_s_r    <= {soft_s_r[1:0], soft_tgl_r};
            rdclr_s_r   <= {rdclr_s_r[1:0], rdclr_tgl_r};
            ctrl_s1_r   <= ctrl_r;
            ctrl_s2_r   <= ctrl_s1_r;
            ctrl_c_r    <= ctrl_c_nxt;
            hrst_cnt_r  <= hrst_cnt_nxt;
            st_r        <= st_nxt;
            cnt_r       <= cnt_nxt;
            coord_c_r   <= coord_c_nxt;
            prev_r      <= prev_nxt;
            coord_tgl_r <= coord_tgl_nxt;
            init_tgl_r  <= init_tgl_nxt;
            int_r       <= int_nxt;
            start_r     <= start_nxt;
        end
    end

    assign fe_start              = start_r;
    assign interrupt_request_low = ~int_r;

endmodule // hjm_measure_ctrl

// ==== src/hjm_pkg.sv ====
package hjm_pkg;

    localparam int CLK_PERIOD_NS  = 50;
    localparam int T_STARTUP_US   = 1000;
    localparam int T_CONV_US      = 450;
    localparam int T_HRST_NS      = 100;
    localparam int T_WAIT_NORM_US = 1000;
    localparam int T_WAIT_IDLE_US = 20000;

    // Least times round up, longest times round down.
    localparam int STARTUP_CYC   = (T_STARTUP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CONV_CYC      = (T_CONV_US * 1000) / CLK_PERIOD_NS;
    localparam int HRST_CYC      = (T_HRST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_NORM_CYC = (T_WAIT_NORM_US * 1000) / CLK_PERIOD_NS;
    localparam int WAIT_IDLE_CYC = (T_WAIT_IDLE_US * 1000) / CLK_PERIOD_NS;

    localparam logic [6:0] SLAVE_ADDR_BASE = 7'h40;

    localparam logic [7:0] REG_CTRL    = 8'h0f;
    localparam logic [7:0] REG_X       = 8'h10;
    localparam logic [7:0] REG_Y       = 8'h11;
    localparam logic [7:0] REG_SHAPE_A = 8'h2b;
    localparam logic [7:0] REG_SHAPE_B = 8'h2c;
    localparam logic [7:0] REG_SHAPE_C = 8'h2d;
    localparam int         SHAPE_NUM   = 3;

    localparam logic [7:0] CTRL_RST  = 8'h00;
    localparam logic [7:0] SHAPE_RST = 8'h00;
    localparam logic [7:0] COORD_RST = 8'h00;

    typedef struct packed {
        logic       idle;
        logic [2:0] timebase;
        logic [1:0] int_mode;
        logic       soft_rst;
        logic       rsvd;
    } hjm_ctrl_t;

    typedef struct packed {
        logic [7:0] x;
        logic [7:0] y;
    } hjm_coord_t;

    typedef enum logic [1:0] {
        INT_EVERY     = 2'h0,
        INT_OFFCENTER = 2'h1,
        INT_CHANGE    = 2'h2,
        INT_OFF       = 2'h3
    } hjm_int_mode_t;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic       rd;
    } hjm_reg_req_t;

    function automatic logic reg_valid(input logic [7:0] a);
        return (a == REG_CTRL) || (a == REG_X) || (a == REG_Y) ||
               (a == REG_SHAPE_A) || (a == REG_SHAPE_B) || (a == REG_SHAPE_C);
    endfunction

endpackage

// ==== src/hjm_sync_filter.sv ====
module hjm_sync_filter #(
    parameter int               W       = 1,
    parameter logic [W-1:0]     RST_VAL = '0
) (
    input  wire logic           clk,
    input  wire logic           rst_n,
    input  wire logic [W-1:0]   d,
    output      logic [W-1:0]   q
);
    import hjm_pkg::*;

    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // A level is taken only once the second and third stages agree, so a spike
    // shorter than one clock period never reaches the output.
    always_comb begin
        q_nxt = q;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
            q    <= RST_VAL;
        end else begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= q_nxt;
        end
    end

endmodule // hjm_sync_filter

// ==== src/hjm_i2c_slave.sv ====
module hjm_i2c_slave (
    input  wire logic                  clk_link,
    input  wire logic                  rst_n,
    input  wire logic                  scl_in,
    input  wire logic                  sda_in,
    input  wire logic                  addr_pin,
    input  wire logic [7:0]            rd_data,
    output      logic [7:0]            ptr,
    output      logic                  sda_drive,
    output      hjm_pkg::hjm_reg_req_t req
);
    import hjm_pkg::*;

    typedef enum logic [2:0] {
        SL_IDLE = 3'b000,
        SL_DEV  = 3'b001,
        SL_REG  = 3'b011,
        SL_WR   = 3'b010,
        SL_RD   = 3'b110
    } hjm_sl_state_t;

    hjm_sl_state_t st_r,    st_nxt;
    logic [3:0]    cnt_r,   cnt_nxt;
    logic          ack_r,   ack_nxt;
    logic [7:0]    shift_r, shift_nxt;
    logic [7:0]    tx_r,    tx_nxt;
    logic [7:0]    ptr_r,   ptr_nxt;
    logic          drive_r, drive_nxt;
    logic          rw_r,    rw_nxt;
    logic          mack_r,  mack_nxt;
    logic          scl_d_r;
    logic          sda_d_r;
    hjm_reg_req_t  req_r,   req_nxt;
    logic          scl_rise;
    logic          scl_fall;
    logic          start_c;
    logic          stop_c;
    logic [6:0]    my_addr;

    assign scl_rise  = scl_in & ~scl_d_r;
    assign scl_fall  = ~scl_in & scl_d_r;
    assign start_c   = scl_in & scl_d_r & sda_d_r & ~sda_in;
    assign stop_c    = scl_in & scl_d_r & ~sda_d_r & sda_in;
    assign my_addr   = SLAVE_ADDR_BASE | {6'h00, addr_pin};
    assign ptr       = ptr_r;
    assign sda_drive = drive_r;
    assign req       = req_r;

    always_comb begin
        st_nxt      = st_r;
        cnt_nxt     = cnt_r;
        ack_nxt     = ack_r;
        shift_nxt   = shift_r;
        tx_nxt      = tx_r;
        ptr_nxt     = ptr_r;
        drive_nxt   = drive_r;
        rw_nxt      = rw_r;
        mack_nxt    = mack_r;
        req_nxt     = req_r;
        req_nxt.wr  = 1'b0;
        req_nxt.rd  = 1'b0;
        if (start_c) begin
            st_nxt    = SL_DEV;
            cnt_nxt   = 4'h0;
            ack_nxt   = 1'b0;
            drive_nxt = 1'b0;
        end else if (stop_c) begin
            st_nxt    = SL_IDLE;
            ack_nxt   = 1'b0;
            drive_nxt = 1'b0;
        end else if (st_r != SL_IDLE) begin
            if (scl_rise) begin
                if (!ack_r && cnt_r < 4'h8) begin
                    shift_nxt = {shift_r[6:0], sda_in};
                    cnt_nxt   = cnt_r + 4'h1;
                end else if (ack_r) begin
                    mack_nxt = sda_in;
                end
            end else if (scl_fall) begin
                if (ack_r) begin
                    ack_nxt   = 1'b0;
                    cnt_nxt   = 4'h0;
                    drive_nxt = 1'b0;
                    if ((st_r == SL_DEV && rw_r) || (st_r == SL_RD && !mack_r)) begin
                        st_nxt      = SL_RD;
                        tx_nxt      = rd_data;
                        drive_nxt   = ~rd_data[7];
                        ptr_nxt     = ptr_r + 8'h01;
                        req_nxt.rd  = 1'b1;
                        req_nxt.addr = ptr_r;
                    end else if (st_r == SL_DEV) begin
                        st_nxt = SL_REG;
                    end else if (st_r == SL_REG) begin
                        st_nxt = SL_WR;
                    end else if (st_r == SL_RD) begin
                        st_nxt = SL_IDLE;
                    end
                end else if (cnt_r == 4'h8) begin
                    ack_nxt = 1'b1;
                    unique case (st_r)
                        SL_DEV: begin
                            if (shift_r[7:1] == my_addr) begin
                                rw_nxt    = shift_r[0];
                                drive_nxt = 1'b1;
                            end else begin
                                st_nxt = SL_IDLE;
                            end
                        end
                        SL_REG: begin
                            ptr_nxt   = shift_r;
                            drive_nxt = reg_valid(shift_r);
                        end
                        SL_WR: begin
                            drive_nxt     = reg_valid(ptr_r);
                            req_nxt.wr    = reg_valid(ptr_r);
                            req_nxt.addr  = ptr_r;
                            req_nxt.wdata = shift_r;
                            ptr_nxt       = ptr_r + 8'h01;
                        end
                        SL_RD: begin
                            drive_nxt = 1'b0;
                        end
                        default: begin
                            st_nxt = SL_IDLE;
                        end
                    endcase
                end else if (st_r == SL_RD) begin
                    drive_nxt = ~tx_r[6];
                    tx_nxt    = {tx_r[6:0], 1'b0};
                end
            end
        end
    end

    always_ff @(posedge clk_link or negedge rst_n) begin
        if (!rst_n) begin
            st_r    <= SL_IDLE;
            cnt_r   <= 4'h0;
            ack_r   <= 1'b0;
            shift_r <= 8'h00;
            tx_r    <= 8'h00;
            ptr_r   <= 8'h00;
            drive_r <= 1'b0;
            rw_r    <= 1'b0;
            mack_r  <= 1'b1;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            req_r   <= '0;
        end else begin
            st_r    <= st_nxt;
            cnt_r   <= cnt_nxt;
            ack_r   <= ack_nxt;
            shift_r <= shift_nxt;
            tx_r    <= tx_nxt;
            ptr_r   <= ptr_nxt;
            drive_r <= drive_nxt;
            rw_r    <= rw_nxt;
            mack_r  <= mack_nxt;
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            req_r   <= req_nxt;
        end
    end

endmodule // hjm_i2c_slave

// ==== verification/hjm_measure_checker.sv ====
module hjm_measure_checker #(
    parameter int STARTUP_CYCLES = 20,
    parameter int CONV_CYCLES    = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_link,
    input wire logic hard_reset_low,
    input wire logic scl_pin,
    input wire logic sda_pin_out,
    input wire logic sda_pin_oe,
    input wire logic fe_start,
    input wire logic interrupt_request_low
);
    logic [15:0] up_r;
    logic [15:0] up_nxt;
    logic [15:0] gap_r;
    logic [15:0] gap_nxt;
    always_comb begin
        up_nxt = (up_r == 16'hffff) ? up_r : up_r + 16'h1;
        gap_nxt = (gap_r == 16'hffff) ? gap_r : gap_r + 16'h1;
        if (!hard_reset_low) up_nxt = 16'h0;
        if (fe_start) gap_nxt = 16'h0;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            up_r <= 16'h0;
            gap_r <= 16'hffff;
        end else begin
            up_r <= up_nxt;
            gap_r <= gap_nxt;
        end
    end
    sequence hrst_seq;
        !hard_reset_low [*8];
    endsequence
    AST_SDA_OPEN_DRAIN: assert property (@(posedge clk_link) disable iff (!rst_n) sda_pin_out == 1'b0)
        else $error("data pin driven high");
    AST_SDA_SCL_LOW: assert property (@(posedge clk_link) disable iff (!rst_n) $changed(sda_pin_oe) |-> !scl_pin)
        else $error("data drive changed while clock high");
    AST_FE_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n) fe_start |=> !fe_start)
        else $error("start pulse too long");
    AST_STARTUP_WAIT: assert property (@(posedge clk) disable iff (!rst_n) fe_start |-> up_r >= STARTUP_CYCLES)
        else $error("measurement before start-up ended");
    AST_HRST_HOLDS: assert property (@(posedge clk) disable iff (!rst_n) hrst_seq |-> !fe_start)
        else $error("measurement while hard reset held");
    AST_CONV_DONE: assert property (@(posedge clk) disable iff (!rst_n) fe_start |-> gap_r > CONV_CYCLES)
        else $error("measurement restarted during conversion");
    AST_INT_AFTER_MEAS: assert property (@(posedge clk) disable iff (!rst_n)
        $fell(interrupt_request_low) |-> gap_r inside {[CONV_CYCLES - 1:CONV_CYCLES + 4]})
        else $error("interrupt not tied to measurement end");
    AST_RESET_VALUES: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(rst_n) |-> interrupt_request_low && !fe_start)
        else $error("outputs not at reset values");
endmodule // hjm_measure_checker

// ==== verification/hjm_host_model.sv ====
module hjm_host_model (
    input  wire logic clk,
    input  wire logic sda,
    output      logic scl,
    output      logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // Each phase spans four core cycles, a little over four link periods.
    task automatic put(input logic c, input logic d);
        @(posedge clk);
        scl <= c;
        sda_low <= ~d;
        repeat (3) @(posedge clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        put(1'b0, ~sda_low);
        put(1'b0, b);
        put(1'b1, b);
        r = sda;
    endtask
    task automatic start();
        put(1'b0, ~sda_low);
        put(1'b0, 1'b1);
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
    endtask
    task automatic stop();
        put(1'b0, ~sda_low);
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(m, a);
    endtask
endmodule // hjm_host_model

// ==== verification/tb_hjm_measure_ctrl.sv ====
module tb_hjm_measure_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    import hjm_pkg::*;
    localparam int ST = 20;
    localparam int CV = 10;
    localparam int WN = 30;
    localparam int WI = 60;
    logic clk = 1'b0;
    logic clk_link = 1'b0;
    logic rst_n = 1'b0;
    logic hard_reset_low = 1'b1;
    logic addr_sel = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_w;
    logic sda_pin_out;
    logic sda_pin_oe;
    logic fe_start;
    logic irq;
    hjm_coord_t fe_coord = '{x: 8'h80, y: 8'h7f};
    int fail_count = 0;
    int check_count = 0;
    int n;
    always #25 clk = ~clk;
    always #24 clk_link = ~clk_link;
    assign sda_w = ~sda_low & (sda_pin_oe ? sda_pin_out : 1'b1);
    hjm_measure_ctrl #(.STARTUP_CYCLES(ST), .CONV_CYCLES(CV), .WAIT_NORM_CYCLES(WN), .WAIT_IDLE_CYCLES(WI)) dut (
        .clk, .rst_n, .clk_link, .hard_reset_low, .scl_pin(scl), .sda_pin_in(sda_w), .sda_pin_out,
        .sda_pin_oe, .addr_sel, .fe_coord, .fe_start, .interrupt_request_low(irq));
    hjm_host_model host (.clk, .sda(sda_w), .scl, .sda_low);
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic flag(input bit ok);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("MISMATCH %0t unexpected value", $time);
        end
    endtask
    task automatic wr(input logic [7:0] b [$], input logic [7:0] ak);
        logic [7:0] q;
        logic a;
        host.start();
        foreach (b[i]) begin
            host.xfer(b[i], 1'b1, q, a);
            flag(a === ak[i]);
        end
        host.stop();
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] ex [$]);
        logic [7:0] q;
        logic a;
        host.start();
        host.xfer(8'h80, 1'b1, q, a);
        host.xfer(ra, 1'b1, q, a);
        host.start();
        host.xfer(8'h81, 1'b1, q, a);
        foreach (ex[i]) begin
            host.xfer(8'hff, i == ex.size() - 1, q, a);
            flag(q === ex[i]);
        end
        host.stop();
    endtask
    task automatic nxt(output int c);
        c = 0;
        do begin
            @(posedge clk);
            #1;
            c++;
        end while (fe_start !== 1'b1 && c < 5000);
        if (fe_start !== 1'b1) flag(1'b0);
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (20) @(posedge clk);
        rd(8'h2b, '{8'h00, 8'h00, 8'h00});
        $display("reset values done");
        wr('{8'h82}, 8'h01);
        wr('{8'h80, 8'h10}, 8'h00);
        addr_sel <= 1'b1;
        wr('{8'h80}, 8'h01);
        wr('{8'h82, 8'h10}, 8'h00);
        addr_sel <= 1'b0;
        $display("address done");
        wr('{8'h80, 8'h2b, 8'ha5, 8'h5a, 8'hc3}, 8'h00);
        rd(8'h2b, '{8'ha5, 8'h5a, 8'hc3});
        wr('{8'h80, 8'h0e, 8'h77, 8'h0c}, 8'h06);
        rd(8'h0e, '{8'h00, 8'h0c});
        $display("pointer done");
        rd(8'h10, '{8'h80, 8'h7f});
        nxt(n);
        nxt(n);
        flag(irq === 1'b1);
        wr('{8'h80, 8'h0f, 8'h00}, 8'h00);
        nxt(n);
        repeat (CV + 6) @(posedge clk);
        flag(irq === 1'b0);
        $display("coordinates done");
        wr('{8'h80, 8'h0f, 8'h0c}, 8'h00);
        repeat (3) nxt(n);
        flag(n >= CV + WN && n <= CV + WN + 4);
        wr('{8'h80, 8'h0f, 8'h9c}, 8'h00);
        repeat (3) nxt(n);
        flag(n >= CV + 2 * WI && n <= CV + 2 * WI + 4);
        $display("timing done");
        hard_reset_low <= 1'b0;
        repeat (10) @(posedge clk);
        hard_reset_low <= 1'b1;
        nxt(n);
        flag(n >= ST && n <= ST + 10);
        rd(8'h2b, '{8'h00});
        rd(8'h0f, '{8'h00});
        $display("hard reset done");
        wr('{8'h80, 8'h2b, 8'h11}, 8'h00);
        wr('{8'h80, 8'h0f, 8'h02}, 8'h00);
        rd(8'h2b, '{8'h00});
        $display("soft reset done");
        close_out();
    end
    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        close_out();
    end
endmodule // tb_hjm_measure_ctrl
bind hjm_measure_ctrl hjm_measure_checker #(.STARTUP_CYCLES(STARTUP_CYCLES), .CONV_CYCLES(CONV_CYCLES)) chk (
    .clk, .rst_n, .clk_link, .hard_reset_low, .scl_pin, .sda_pin_out, .sda_pin_oe, .fe_start,
    .interrupt_request_low);
